// [hw/iic_conditioner.sv]
`timescale 1ns/1ps
`include "iic_consts.svh"
module iic_conditioner (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic bridge_reset_n,
  input wire logic advanced_variant,
  input wire iic_pkg::iic_lines_t request_in,
  input wire logic clock_chip_interrupt_request_n,
  input wire iic_pkg::iic_lines_t edge_level_control,
  input wire iic_pkg::iic_lines_t request_clear,
  input wire logic ack_valid,
  input wire iic_pkg::iic_line_id_t ack_line,
  input wire logic io_read,
  input wire logic [15:0] io_addr,
  output logic [15:0] pending,
  output logic ack_answer_valid,
  output logic [3:0] ack_vector_line,
  output logic ack_spurious,
  output logic keyboard_latch
);
  iic_pkg::iic_lines_t raw, sync1, sync2, prev, mode, edge_hold;
  iic_pkg::iic_lines_t next_sync1, next_sync2, next_prev, next_mode, next_edge_hold;
  logic [15:0] next_pending;
  logic next_ack_answer_valid, next_ack_spurious, next_keyboard_latch;
  logic [3:0] next_ack_vector_line;
  logic reset_all;

  // One decode serves the clearing logic and both of its checkers, kbd_clear_a and kbd_keep_a
  function automatic logic iic_kbd_read(input logic rd, input logic [15:0] addr);
    iic_kbd_read = rd && addr == `IIC_KBD_PORT;
  endfunction : iic_kbd_read

  // Either reset forces edge mode; once bridge reset ends, mode takes edge_level_control again on the next clock
  assign reset_all = !resetn || !bridge_reset_n;

  // Clock chip line is inverted to active high before the synchroniser
  always_comb
  begin
    raw = request_in;
    raw[`IIC_CLOCK_LINE] = !clock_chip_interrupt_request_n; // [R07]
  end

  always_comb
  begin
    next_sync1 = raw; // [R01]
    next_sync2 = sync1; // [R01]
    next_prev = sync2;
    next_mode = edge_level_control; // [R02]
    if (reset_all)
      next_mode = `IIC_MODE_RESET; // [R03]
    next_edge_hold = edge_hold & ~request_clear;
    next_edge_hold = next_edge_hold | (sync2 & ~prev & ~mode); // [R08]
    next_pending = (edge_hold & ~mode) | (sync2 & mode); // [R08]
    next_keyboard_latch = keyboard_latch;
    if (advanced_variant && iic_kbd_read(io_read, io_addr))
      next_keyboard_latch = 1'b0; // [R06]
    // Set wins over the clearing read
    if (advanced_variant && sync2[`IIC_KBD_LINE] && !prev[`IIC_KBD_LINE])
      next_keyboard_latch = 1'b1; // [R06]
    next_ack_answer_valid = ack_valid;
    next_ack_vector_line = ack_line;
    next_ack_spurious = 1'b0;
    // Line must still be pending at acknowledge, else default vector
    if (ack_valid && !pending[ack_line])
    begin
      next_ack_vector_line = `IIC_SPURIOUS_LINE; // [R05] [R04]
      next_ack_spurious = 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      sync1 <= '0;
      sync2 <= '0;
      prev <= '0;
      mode <= `IIC_MODE_RESET;
      edge_hold <= '0;
      pending <= '0;
      keyboard_latch <= 1'b0;
      ack_answer_valid <= 1'b0;
      ack_vector_line <= '0;
      ack_spurious <= 1'b0;
    end
    else
    begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      prev <= next_prev;
      mode <= next_mode;
      edge_hold <= next_edge_hold;
      pending <= next_pending;
      keyboard_latch <= next_keyboard_latch;
      ack_answer_valid <= next_ack_answer_valid;
      ack_vector_line <= next_ack_vector_line;
      ack_spurious <= next_ack_spurious;
    end
  end

  sequence kbd_rise_s;
    advanced_variant && sync2[`IIC_KBD_LINE] && !prev[`IIC_KBD_LINE];
  endsequence

  mode_reset_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R03]
    !bridge_reset_n |=> mode == '0)
    else $error("mode not forced to edge under bridge reset");
  mode_follow_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R02]
    resetn && bridge_reset_n |=> mode == $past(edge_level_control))
    else $error("mode did not follow control");
  sync_delay_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R01]
    resetn |-> ##2 sync2 == $past(raw, 2))
    else $error("synchroniser delay wrong");
  clock_low_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R07]
    resetn |-> ##2 sync2[`IIC_CLOCK_LINE] == !$past(clock_chip_interrupt_request_n, 2))
    else $error("clock chip request polarity wrong");
  level_pend_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R08]
    mode[3] && sync2[3] |=> pending[3])
    else $error("level request not presented");
  edge_pend_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R08]
    !mode[3] && sync2[3] && !prev[3] && !request_clear[3] |=> ##1 pending[3] || mode[3])
    else $error("edge request not recorded");
  kbd_latch_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R06]
    kbd_rise_s |=> keyboard_latch)
    else $error("keyboard edge not latched");
  kbd_clear_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R06]
    iic_kbd_read(io_read, io_addr) && advanced_variant
    && !(sync2[`IIC_KBD_LINE] && !prev[`IIC_KBD_LINE])
    |=> !keyboard_latch)
    else $error("keyboard latch not cleared by read");
  spurious_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R05]
    ack_valid && !pending[ack_line] |=> ack_spurious && ack_vector_line == `IIC_SPURIOUS_LINE)
    else $error("spurious acknowledge not redirected");

  sequence ack_take_s;
    ack_valid && pending[ack_line];
  endsequence

  sequence ack_miss_s;
    ack_valid && !pending[ack_line];
  endsequence

  // Answer follows each acknowledge one cycle later and lasts as long as it; a stuck answer would acknowledge twice downstream
  ack_pulse_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R05]
    ack_valid
    |=> ack_answer_valid)
    else $error("acknowledge answer missing");

  ack_quiet_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R05]
    !ack_valid
    |=> !ack_answer_valid && !ack_spurious)
    else $error("acknowledge answer without acknowledge");

  ack_pass_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R04]
    ack_take_s
    |=> !ack_spurious && ack_vector_line == $past(ack_line))
    else $error("held request answered as spurious");

  ack_miss_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R05]
    ack_miss_s
    |=> ack_answer_valid && ack_spurious)
    else $error("dropped request not flagged");

  // No disable here, so the cycle right after reset is checked as well
  reset_clear_a: assert property (@(posedge sys_clk) // [R03]
    !resetn
    |=> mode == `IIC_MODE_RESET && pending == '0 && !keyboard_latch && !ack_answer_valid)
    else $error("state not cleared by reset");

  // Edge history must trail the synchroniser by exactly one cycle
  prev_track_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R01]
    resetn |-> ##1 prev == $past(sync2))
    else $error("edge history lags the synchroniser");

  // Without the advanced controller the keyboard latch must never move
  kbd_still_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R06]
    !advanced_variant
    |=> $stable(keyboard_latch))
    else $error("keyboard latch moved in the plain variant");

  kbd_keep_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R06]
    keyboard_latch && !iic_kbd_read(io_read, io_addr)
    |=> keyboard_latch)
    else $error("keyboard latch lost without a read");

  // Same checks on every line; line 8 carries the inverted clock chip request
  for (genvar gi = 0; gi < `IIC_LINES; gi++)
  begin : g_line
    // Level mode follows the synchronised input one cycle later
    line_level_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R08]
      mode[gi] && sync2[gi]
      |=> pending[gi])
      else $error("level request not presented");

    line_quiet_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R08]
      mode[gi] && !sync2[gi]
      |=> !pending[gi])
      else $error("level request presented while inactive");

    // Edge mode records a rise and keeps it until cleared
    line_rise_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R08]
      !mode[gi] && sync2[gi] && !prev[gi]
      |=> edge_hold[gi])
      else $error("edge request not recorded");

    line_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R08]
      !mode[gi] && edge_hold[gi]
      |=> pending[gi])
      else $error("held edge request not presented");

    line_only_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R08]
      !edge_hold[gi] && !(sync2[gi] && !prev[gi])
      |=> !edge_hold[gi])
      else $error("edge request recorded without a transition");

    // A fresh edge in the clearing cycle survives, so no request is lost
    line_clear_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R08]
      request_clear[gi] && !(sync2[gi] && !prev[gi] && !mode[gi])
      |=> !edge_hold[gi])
      else $error("held edge request not cleared");
  end : g_line
endmodule : iic_conditioner

// [hw/iic_consts.svh]
// Function
// R01: Every request input is asynchronous and passes two flip-flops before use.
// R02: Software selects edge or level recognition per request line.
// R03: Bridge reset forces every line into edge-triggered recognition.
// R04: Without the advanced controller, sources hold requests until acknowledged.
// R05: Request gone before acknowledge completes answers with line 7 default vector.
// R06: Advanced variant latches keyboard line rising edge; read of 60h clears it.
// R07: Clock chip request is active low; its mode is selectable too.
// R08: Edge mode records inactive-to-active transitions; level mode follows the level.
`ifndef IIC_CONSTS_SVH
`define IIC_CONSTS_SVH
`define IIC_LINES 16
`define IIC_CLOCK_LINE 8
`define IIC_KBD_LINE 1
`define IIC_SPURIOUS_LINE 4'h7
`define IIC_KBD_PORT 16'h0060
`define IIC_MODE_RESET 16'h0000
`endif

// [hw/iic_pkg.sv]
package iic_pkg;
  typedef logic [15:0] iic_lines_t;
  typedef logic [3:0] iic_line_id_t;
endpackage : iic_pkg

// [bench/iic_source.sv]
`timescale 1ns/1ps
module iic_source (
  input wire logic sys_clk,
  input wire logic [15:0] want,
  input wire logic [15:0] clr,
  output logic [15:0] lines = 16'h0000
);
  always @(posedge sys_clk) lines <= want | (lines & ~clr); // Held until cleared by clr
endmodule : iic_source

// [bench/iic_conditioner_test.sv]
`timescale 1ns/1ps
module iic_conditioner_test;
  logic sys_clk = 0, resetn = 0, brst_n = 1, chip_req_n = 1, ackv = 0, iord = 0, adv = 1;
  logic [15:0] clr = 16'h0000, want = 16'h0000, req, pend;
  logic [15:0] elc = 16'h0020, ioa = 16'h0060;
  logic [3:0] ackl = 4'h0;
  wire [15:0] outs;
  int fails = 0, checks = 0;
  initial forever #10 sys_clk = ~sys_clk;
  // Tests need under a hundred cycles; the limit leaves a wide margin
  initial #100000 stop_test(1);
  iic_source u_src (.sys_clk(sys_clk), .want(want), .clr(clr), .lines(req));
  iic_conditioner u_dut (.sys_clk(sys_clk), .resetn(resetn), .bridge_reset_n(brst_n),
    .advanced_variant(adv), .request_in(req), .clock_chip_interrupt_request_n(chip_req_n),
    .edge_level_control(elc), .request_clear(clr), .ack_valid(ackv), .ack_line(ackl),
    .io_read(iord), .io_addr(ioa), .pending(pend), .ack_answer_valid(outs[5]),
    .ack_vector_line(outs[3:0]), .ack_spurious(outs[4]), .keyboard_latch(outs[6]));
  assign outs[15:7] = '0;
  task chk(input logic [15:0] got, exp);
    checks++;
    if (got !== exp) $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    fails += (got !== exp);
  endtask : chk
  // Stimulus moves at a rising edge; results are read at the falling edge n+1 cycles later
  task drive(input logic [15:0] w, c, input logic a, input logic [3:0] l, input logic r,
    input int n);
    @(posedge sys_clk);
    want <= w;
    clr <= c;
    ackv <= a;
    ackl <= l;
    iord <= r;
    @(posedge sys_clk);
    clr <= 16'h0000;
    {ackv, iord} <= 2'b00;
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : drive
  task t_edge;
    drive(16'h0008, 16'h0000, 1'b0, 4'h0, 1'b0, 6);
    chk(pend, 16'h0008);
    drive(16'h0008, 16'h0000, 1'b1, 4'h6, 1'b0, 0);
    chk(outs & 16'h003F, 16'h0037); // Line 6 never raised, so default vector
    drive(16'h0008, 16'h0000, 1'b1, 4'h3, 1'b0, 0);
    chk(outs & 16'h003F, 16'h0023);
    drive(16'h0008, 16'h0008, 1'b0, 4'h0, 1'b0, 3);
    chk(pend, 16'h0000); // Line 3 still high, no new edge
  endtask : t_edge
  task t_modes;
    @(posedge sys_clk);
    brst_n <= 1'b0;
    drive(16'h0020, 16'h0000, 1'b0, 4'h0, 1'b0, 6);
    drive(16'h0020, 16'h0028, 1'b0, 4'h0, 1'b0, 4); // Line 5 stays high
    chk(pend, 16'h0000);
    @(posedge sys_clk);
    brst_n <= 1'b1;
    drive(16'h0020, 16'h0000, 1'b0, 4'h0, 1'b0, 4);
    chk(pend, 16'h0020);
    drive(16'h0000, 16'h0020, 1'b0, 4'h0, 1'b0, 4);
    chk(pend, 16'h0000);
    @(posedge sys_clk);
    chip_req_n <= 1'b0;
    drive(16'h0002, 16'h0000, 1'b0, 4'h0, 1'b0, 6);
    chk({pend[14:0], outs[6]}, 16'h0205);
    @(posedge sys_clk);
    ioa <= 16'h0064;
    drive(16'h0002, 16'h0000, 1'b0, 4'h0, 1'b1, 1);
    chk(outs & 16'h0040, 16'h0040);
    @(posedge sys_clk);
    ioa <= 16'h0060;
    drive(16'h0002, 16'h0000, 1'b0, 4'h0, 1'b1, 1);
    chk(outs & 16'h0040, 16'h0000);
    @(posedge sys_clk);
    adv <= 1'b0;
    drive(16'h0000, 16'h0002, 1'b0, 4'h0, 1'b0, 4);
    drive(16'h0002, 16'h0000, 1'b0, 4'h0, 1'b0, 6);
    chk(outs & 16'h0040, 16'h0000);
  endtask : t_modes
  task stop_test(input int hang);
    fails += hang;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  initial
  begin
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    t_edge();
    t_modes();
    stop_test(0);
  end
endmodule : iic_conditioner_test
